// ===== adc_seq_consts.vh
// Offsets, field positions, reset values and timing counts of the converter sequencer
// What this block does
// R1: Convert selected input to ten-bit unsigned code
// R2: Sleep conversions need private RC clock
// R3: Seven pin bits select analog; bit 7 zero
// R4: Analog pin disables its digital input buffer
// R5: Channel code 000-110 routes channels 0-6
// R6: Halve bit doubles divided clock, not RC
// R7: Completion loads result, clears start, sets flag
// R8: Format bit picks right or left justification
// R9: Reference field selects four reference pairings
// R10: Reference pins analog before external references
// R11: Configure everything and power on first
// R12: Wait acquisition time after channel change
// R13: Start by writing start bit while powered
// R14: Poll start bit or await interrupt
// R15: Interrupt needs flag and three enables set
// R16: Two conversion periods hold off next acquisition
// R17: Analog pins set as inputs by software
// R18: Clock select: divide 2/8/32 or RC
// R19: Conversion takes ten conversion-clock periods
// R20: Clearing start aborts; result kept; auto reacquire
// R21: Power off idles converter, ignores starts
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ADC_IDX_PIN_SELECT 8'h9B
`define ADC_IDX_CONTROL_B 8'h9F
`define ADC_IDX_CONTROL_A 8'h9C
`define ADC_IDX_RESULT_HIGH 8'h9D
`define ADC_IDX_RESULT_LOW 8'h9E
`define ADC_IDX_IRQ_CONTROL 8'h9A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADC_A_POWER 0
`define ADC_A_START 2
`define ADC_A_CHAN_LSB 3
`define ADC_A_CLKSEL_LSB 6
`define ADC_B_REF_LSB 4
`define ADC_B_HALVE 6
`define ADC_B_FORMAT 7
`define ADC_IRQ_FLAG 0
`define ADC_IRQ_ENABLE 1
`define ADC_IRQ_PERIPH 2
`define ADC_IRQ_GLOBAL 3

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define ADC_PIN_SELECT_RESET 7'h7F
`define ADC_CLKSEL_RC 2'h3
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing counts, in conversion-clock periods or system clocks
// ----------------------------------------------------------------
`define ADC_DIV_BASE 7'h02
`define ADC_HOLDOFF_TADS 2'h2
`define ADC_RESULT_BITS 10

`endif

// ===== conv_clock_gen.v
// Conversion clock period tick generator: divided system clock or private RC clock
`include "adc_seq_consts.vh"
`default_nettype none

module conv_clock_gen (
    input wire core_clk,
    input wire rst_n,
    input wire run,
    input wire [1:0] clock_select,
    input wire clock_halve,
    input wire rc_osc_in,
    output reg tad_tick
);

    reg rc_meta;
    reg rc_sync2;
    reg rc_sync3;
    reg rc_level;
    reg [6:0] div_cnt;
    wire [3:0] div_shift;
    wire [6:0] div_last;
    wire rc_rise;

    // Divisor 2, 8 or 32, doubled when halving is on
    assign div_shift = {1'b0, clock_select, 1'b0} + {3'h0, clock_halve}; // [R6] [R18]
    assign div_last = (`ADC_DIV_BASE << div_shift) - 7'h01;
    // Accepted rising edge of the RC oscillator
    assign rc_rise = (rc_sync2 == rc_sync3) && rc_sync3 && !rc_level;

    // Synchroniser for the free-running RC oscillator
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_meta <= 1'b0;
            rc_sync2 <= 1'b0;
            rc_sync3 <= 1'b0;
            rc_level <= 1'b0;
        end else begin
            rc_meta <= rc_osc_in;
            rc_sync2 <= rc_meta;
            rc_sync3 <= rc_sync2;
            if (rc_sync2 == rc_sync3) begin
                rc_level <= rc_sync3;
            end
        end
    end

    // One tick per conversion-clock period while running
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 7'h00;
            tad_tick <= 1'b0;
        end else if (!run) begin
            div_cnt <= 7'h00;
            tad_tick <= 1'b0;
        end else if (clock_select == `ADC_CLKSEL_RC) begin
            div_cnt <= 7'h00;
            tad_tick <= rc_rise; // [R18] [R6]
        end else if (div_cnt >= div_last) begin
            div_cnt <= 7'h00;
            tad_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 7'h01;
            tad_tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== adc_sequencer_control.v
// Converter sequencer: register file over AXI4-Lite, sequencing, SAR and result justification
//
// Chosen here: register access over AXI4-Lite.
`include "adc_seq_consts.vh"
`default_nettype none

module adc_sequencer_control #(
    parameter ADDR_W = 10
) (
    input wire core_clk,
    input wire rst_n,
    // AXI4-Lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog core
    output reg [2:0] channel_select,
    output reg [1:0] reference_select,
    output reg [6:0] digital_input_disable,
    output reg sample_enable,
    output reg [9:0] dac_code,
    input wire comparator_above,
    input wire rc_osc_in,
    // Interrupt request
    output wire irq
);

    // ----------------------------------------------------------------
    // States and declarations
    // ----------------------------------------------------------------
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_ACQ = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam [1:0] ST_HOLD = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [6:0] pin_analog_bits;
    reg [1:0] conv_clock_select;
    reg converter_power;
    reg start_done;
    reg result_format;
    reg conv_clock_halve;
    reg [7:0] result_high_byte;
    reg [7:0] result_low_byte;
    reg conversion_complete_flag;
    reg conversion_complete_enable;
    reg peripheral_irq_enable;
    reg global_irq_enable;
    reg [9:0] sar_value;
    reg [9:0] sar_mask;
    reg [1:0] hold_cnt;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_index;
    reg [7:0] w_data;
    reg w_lane0;
    wire tad_tick;
    wire run_clock;
    wire do_write;
    wire wr_lane;
    wire wr_a;
    wire next_power;
    wire conv_done;
    wire [9:0] decided;
    wire [7:0] ar_index;
    wire ar_mapped;
    wire aw_mapped;

    // Byte address to register index
    function [7:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    // Index hits one of the six registers
    function is_mapped;
        input [7:0] idx;
        begin
            is_mapped = (idx == `ADC_IDX_PIN_SELECT) || (idx == `ADC_IDX_CONTROL_B) ||
                (idx == `ADC_IDX_CONTROL_A) || (idx == `ADC_IDX_RESULT_HIGH) ||
                (idx == `ADC_IDX_RESULT_LOW) || (idx == `ADC_IDX_IRQ_CONTROL);
        end
    endfunction

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    assign run_clock = (state == ST_CONV) || (state == ST_HOLD);

    conv_clock_gen u_clock (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(run_clock),
        .clock_select(conv_clock_select),
        .clock_halve(conv_clock_halve),
        .rc_osc_in(rc_osc_in),
        .tad_tick(tad_tick)
    );

    // ----------------------------------------------------------------
    // Bus write and read handshakes
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign aw_mapped = is_mapped(aw_index);
    assign wr_lane = do_write && w_lane0 && aw_mapped;
    assign wr_a = wr_lane && (aw_index == `ADC_IDX_CONTROL_A);
    assign next_power = wr_a ? w_data[`ADC_A_POWER] : converter_power;
    assign ar_index = reg_index(s_axi_araddr);
    assign ar_mapped = is_mapped(ar_index);

    // Address and data latches, write response
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_index <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_index <= reg_index(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_mapped ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data, unused bits read as zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ADC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ar_mapped ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
            case (ar_index)
                `ADC_IDX_PIN_SELECT: s_axi_rdata <= {25'h0, pin_analog_bits}; // [R3]
                `ADC_IDX_CONTROL_A: s_axi_rdata <= {24'h0, conv_clock_select, channel_select,
                    start_done, 1'b0, converter_power}; // [R14]
                `ADC_IDX_CONTROL_B: s_axi_rdata <= {24'h0, result_format, conv_clock_halve,
                    reference_select, 4'h0};
                `ADC_IDX_RESULT_HIGH: s_axi_rdata <= {24'h0, result_high_byte};
                `ADC_IDX_RESULT_LOW: s_axi_rdata <= {24'h0, result_low_byte};
                `ADC_IDX_IRQ_CONTROL: s_axi_rdata <= {28'h0, global_irq_enable,
                    peripheral_irq_enable, conversion_complete_enable,
                    conversion_complete_flag};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_analog_bits <= `ADC_PIN_SELECT_RESET;
            digital_input_disable <= `ADC_PIN_SELECT_RESET;
            conv_clock_select <= 2'h0;
            channel_select <= 3'h0;
            converter_power <= 1'b0;
            result_format <= 1'b0;
            conv_clock_halve <= 1'b0;
            reference_select <= 2'h0;
            conversion_complete_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (wr_lane) begin
            case (aw_index)
                `ADC_IDX_PIN_SELECT: begin
                    pin_analog_bits <= w_data[6:0]; // [R3]
                    digital_input_disable <= w_data[6:0]; // [R4]
                end
                `ADC_IDX_CONTROL_A: begin
                    conv_clock_select <= w_data[`ADC_A_CLKSEL_LSB+1:`ADC_A_CLKSEL_LSB]; // [R18]
                    channel_select <= w_data[`ADC_A_CHAN_LSB+2:`ADC_A_CHAN_LSB]; // [R5]
                    converter_power <= w_data[`ADC_A_POWER];
                end
                `ADC_IDX_CONTROL_B: begin
                    result_format <= w_data[`ADC_B_FORMAT];
                    conv_clock_halve <= w_data[`ADC_B_HALVE]; // [R6]
                    reference_select <= w_data[`ADC_B_REF_LSB+1:`ADC_B_REF_LSB]; // [R9]
                end
                `ADC_IDX_IRQ_CONTROL: begin
                    conversion_complete_enable <= w_data[`ADC_IRQ_ENABLE];
                    peripheral_irq_enable <= w_data[`ADC_IRQ_PERIPH];
                    global_irq_enable <= w_data[`ADC_IRQ_GLOBAL];
                end
                default: begin
                    pin_analog_bits <= pin_analog_bits;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign conv_done = (state == ST_CONV) && start_done && tad_tick && sar_mask[0];
    assign decided = comparator_above ? (sar_value | sar_mask) : sar_value;

    // Next state of the sequencer
    always @* begin
        next_state = state;
        if (!converter_power) begin
            next_state = ST_OFF; // [R21]
        end else begin
            case (state)
                ST_OFF: next_state = ST_ACQ;
                ST_ACQ: begin
                    if (start_done) begin
                        next_state = ST_CONV; // [R13]
                    end
                end
                ST_CONV: begin
                    if (!start_done || conv_done) begin
                        next_state = ST_HOLD; // [R20] [R16]
                    end
                end
                ST_HOLD: begin
                    if (tad_tick && (hold_cnt == `ADC_HOLDOFF_TADS - 2'h1)) begin
                        next_state = ST_ACQ; // [R16] [R20]
                    end
                end
                default: next_state = ST_OFF;
            endcase
        end
    end

    // State, start bit, successive approximation and holdoff count
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            start_done <= 1'b0;
            sample_enable <= 1'b0;
            sar_value <= 10'h000;
            sar_mask <= 10'h200;
            dac_code <= 10'h000;
            hold_cnt <= 2'h0;
        end else begin
            state <= next_state;
            sample_enable <= (next_state == ST_ACQ);
            if (!next_power) begin
                start_done <= 1'b0; // [R21]
            end else if (wr_a && w_data[`ADC_A_START]) begin
                start_done <= 1'b1; // [R13]
            end else if (conv_done) begin
                start_done <= 1'b0; // [R7]
            end else if (wr_a) begin
                start_done <= 1'b0; // [R20]
            end
            if (state != ST_CONV) begin
                sar_value <= 10'h000;
                sar_mask <= 10'h200;
                dac_code <= 10'h200;
            end else if (tad_tick) begin
                sar_value <= decided; // [R1] [R19]
                sar_mask <= sar_mask >> 1;
                dac_code <= decided | (sar_mask >> 1);
            end
            if (state != ST_HOLD) begin
                hold_cnt <= 2'h0;
            end else if (tad_tick) begin
                hold_cnt <= hold_cnt + 2'h1; // [R16]
            end
        end
    end

    // ----------------------------------------------------------------
    // Result pair and completion flag
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
            conversion_complete_flag <= 1'b0;
        end else begin
            if (conv_done) begin
                if (result_format) begin
                    result_high_byte <= {6'h00, decided[9:8]}; // [R8] [R7]
                    result_low_byte <= decided[7:0];
                end else begin
                    result_high_byte <= decided[9:2]; // [R8] [R7]
                    result_low_byte <= {decided[1:0], 6'h00};
                end
            end else if (wr_lane && (aw_index == `ADC_IDX_RESULT_HIGH)) begin
                result_high_byte <= w_data;
            end else if (wr_lane && (aw_index == `ADC_IDX_RESULT_LOW)) begin
                result_low_byte <= w_data;
            end
            // Completion wins over a software clear in the same cycle
            if (conv_done) begin
                conversion_complete_flag <= 1'b1; // [R7]
            end else if (wr_lane && (aw_index == `ADC_IDX_IRQ_CONTROL)) begin
                conversion_complete_flag <= w_data[`ADC_IRQ_FLAG];
            end
        end
    end

    // Interrupt only with flag and all three enables
    assign irq = conversion_complete_flag && conversion_complete_enable &&
        peripheral_irq_enable && global_irq_enable; // [R15]

endmodule

`default_nettype wire

// ===== adc_seq_asserts.sv
// Checker of bus answers and conversion sequencing
`default_nettype none
module adc_seq_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic sample_enable,
    input wire logic [9:0] dac_code
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Sequences and assertions
    // ----
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Both write channels taken at one edge
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Converter leaves acquisition
    sequence conv_begins;
        $fell(sample_enable);
    endsequence
    AST_B_ANSWER: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_CONV_MSB: assert property (conv_begins |-> dac_code == 10'h200)
        else $error("first trial code wrong");
    AST_CONV_MIN: assert property (conv_begins |=> !sample_enable [*8])
        else $error("conversion too short");
    AST_HOLD_BEFORE_ACQ: assert property ($rose(sample_enable) |->
        !$past(sample_enable, 2) && !$past(sample_enable, 3))
        else $error("acquisition resumed without holdoff");
endmodule
bind adc_sequencer_control adc_seq_asserts chk (.core_clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .sample_enable, .dac_code);
`default_nettype wire

// ===== analog_core_model.sv
// Behavioural analog core: input mux, hold capacitor, comparator and private RC clock
`default_nettype none
module analog_core_model (
    input wire logic core_clk,
    input wire logic [2:0] channel_select,
    input wire logic sample_enable,
    input wire logic [9:0] dac_code,
    input wire logic [79:0] levels,
    output logic comparator_above,
    output logic rc_osc_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] held = 10'h000;
    // Hold capacitor tracks the routed channel while connected
    always @(posedge core_clk) begin
        if (sample_enable) begin
            held <= levels[channel_select * 10 +: 10];
        end
    end
    // Comparator against the trial code
    assign comparator_above = (held >= dac_code);
    // Private RC oscillator, unrelated in phase to the core clock
    initial begin
        rc_osc_in = 1'b0;
        forever #23 rc_osc_in = ~rc_osc_in;
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench: registers, conversion timing, justification, interrupt and abort
`include "adc_seq_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, se_q, irq_q;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [79:0] levels;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire sample_enable, comparator_above, rc_osc_in, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, reference_select;
    wire [31:0] s_axi_rdata;
    wire [2:0] channel_select;
    wire [6:0] digital_input_disable;
    wire [9:0] dac_code;
    int fail_count, samples_checked, cyc, t_fall, t_irq, t_rise;

    adc_sequencer_control dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_select,
        .reference_select, .digital_input_disable, .sample_enable, .dac_code,
        .comparator_above, .rc_osc_in, .irq);
    analog_core_model core (.core_clk, .channel_select, .sample_enable, .dac_code, .levels,
        .comparator_above, .rc_osc_in);

    // Core clock, 5 ns period
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Edge stamps, taken mid-cycle
    always @(negedge core_clk) begin
        cyc++;
        if (se_q && !sample_enable) t_fall = cyc;
        if (!se_q && sample_enable) t_rise = cyc;
        if (!irq_q && irq) t_irq = cyc;
        se_q = sample_enable;
        irq_q = irq;
    end
    // ----
    // Comparison and closing
    // ----
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic timeout(input string what);
        fail_count++;
        $display("mismatch %s expected completion seen timeout", what);
        finish_test();
    endtask
    // ----
    // Register bus master
    // ----
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic ta, tw, got_b;
        logic [1:0] r;
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            got_b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (got_b) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) timeout("write");
        check("write response", er, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        logic ta, got_r;
        logic [1:0] r;
        logic [31:0] d;
        int n;
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = s_axi_arvalid && s_axi_arready;
            got_r = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (got_r) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) timeout("read");
        check("read data", {24'h000000, exp}, d);
        check("read response", er, r);
    endtask
    task automatic wait_acq();
        int n;
        for (n = 0; n < 400 && sample_enable !== 1'b1; n++) @(posedge core_clk);
        if (n == 400) timeout("acquire");
    endtask
    // One conversion; format is halve bit; div 0 is RC
    task automatic conv(input logic [1:0] cs, input logic h, input logic [2:0] ch, input int div);
        logic [9:0] v;
        int n;
        v = levels[ch * 10 +: 10];
        wr(`ADC_IDX_CONTROL_B, {h, h, 6'h00});
        wr(`ADC_IDX_CONTROL_A, {cs, ch, 3'b001});
        check("channel", ch, channel_select);
        repeat (20) @(posedge core_clk);
        wr(`ADC_IDX_IRQ_CONTROL, 8'h0E);
        check("irq after clear", 1'b0, irq);
        wr(`ADC_IDX_CONTROL_A, {cs, ch, 3'b101});
        for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge core_clk);
        if (n == 2000) timeout("completion");
        if (div > 0) check_range("conversion clocks", 9 * div, 10 * div + 1, t_irq - t_fall);
        rd(`ADC_IDX_CONTROL_A, {cs, ch, 3'b001});
        rd(`ADC_IDX_RESULT_HIGH, h ? {6'h00, v[9:8]} : v[9:2]);
        rd(`ADC_IDX_RESULT_LOW, h ? v[7:0] : {v[1:0], 6'h00});
        wait_acq();
        if (div > 0) check_range("holdoff clocks", div, 2 * div + 1, t_rise - t_irq);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        static logic [7:0] zr [5] = '{`ADC_IDX_CONTROL_A, `ADC_IDX_CONTROL_B, `ADC_IDX_RESULT_HIGH,
            `ADC_IDX_RESULT_LOW, `ADC_IDX_IRQ_CONTROL};
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {se_q, irq_q} = 2'b00;
        s_axi_awaddr = 10'h000;
        s_axi_araddr = 10'h000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        levels = {10'h000, 10'h0C3, 10'h1FF, 10'h200, 10'h15A, 10'h2A5, 10'h000, 10'h3FF};
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`ADC_IDX_PIN_SELECT, 8'h7F);
        check("input buffer disable", 7'h7F, digital_input_disable);
        foreach (zr[i]) rd(zr[i], 8'h00);
        wr(`ADC_IDX_PIN_SELECT, 8'hFF);
        rd(`ADC_IDX_PIN_SELECT, 8'h7F);
        wr(`ADC_IDX_PIN_SELECT, 8'h0C);
        check("input buffer disable", 7'h0C, digital_input_disable);
        wr(8'h10, 8'h55, 2'h2);
        rd(8'h10, 8'h00, 2'h2);
        wr(`ADC_IDX_CONTROL_A, 8'h04);
        rd(`ADC_IDX_CONTROL_A, 8'h00);
        check("sample enable", 1'b0, sample_enable);
        for (int i = 0; i < 4; i++) begin
            wr(`ADC_IDX_CONTROL_B, {2'b00, 2'(i), 4'h0});
            check("reference", i, reference_select);
        end
        for (int i = 0; i < 6; i++) begin
            conv(2'(i / 2), 1'(i % 2), 3'(i), (2 << (2 * (i / 2))) << (i % 2));
        end
        conv(2'h3, 1'b1, 3'h6, 0);
        wr(`ADC_IDX_IRQ_CONTROL, 8'h0E);
        wr(`ADC_IDX_CONTROL_A, 8'hA5);
        repeat (30) @(posedge core_clk);
        wr(`ADC_IDX_CONTROL_A, 8'hA1);
        rd(`ADC_IDX_IRQ_CONTROL, 8'h0E);
        rd(`ADC_IDX_RESULT_HIGH, 8'h00);
        rd(`ADC_IDX_RESULT_LOW, 8'hC3);
        wait_acq();
        check("sample enable", 1'b1, sample_enable);
        finish_test();
    end
endmodule
`default_nettype wire
